// ===== rtl/imsa_defines.vh
// Register map, field positions, reset values and counts of the I2C master
`ifndef IMSA_DEFINES_VH
`define IMSA_DEFINES_VH

// Register addresses on the plain register port
`define IMSA_ADDR_CTRL 2'h0
`define IMSA_ADDR_STAT 2'h1
`define IMSA_ADDR_RATE 2'h2
`define IMSA_ADDR_BUF 2'h3

// Control register fields
`define IMSA_CTRL_UNIT_EN 0
`define IMSA_CTRL_START 1
`define IMSA_CTRL_RSTART 2
`define IMSA_CTRL_STOP 3
`define IMSA_CTRL_ACK 4
`define IMSA_CTRL_ACK_DATA 5
`define IMSA_CTRL_EVENT_IE 6
`define IMSA_CTRL_COLL_IE 7

// Status register fields
`define IMSA_STAT_START_SEEN 0
`define IMSA_STAT_STOP_SEEN 1
`define IMSA_STAT_BUF_FULL 2
`define IMSA_STAT_WRITE_COLLISION_FLAG 3
`define IMSA_STAT_BCOL 4
`define IMSA_STAT_EVENT 5
`define IMSA_STAT_BUSY 6
`define IMSA_STAT_ACK_STATUS 7

// Reset values
`define IMSA_RATE_RST 8'h13
`define IMSA_BUF_RST 8'h00

// Bit counts of one byte transfer
`define IMSA_LAST_DATA_BIT 4'h7
`define IMSA_ACK_BIT 4'h8

`endif

// ===== rtl/imsa_master.v
// I2C master sequencer: ack, stop, start, restart, transmit, arbitration
//
// Operation
// - Ack enable holds SCL low, shows ack data
// - Ack: period, release SCL, period, SCL low
// - Buffer write during ack or stop: collision
// - Stop: SDA low, count, SCL up, SDA up
// - Stop seen, period later clear, event
// - In sleep, enabled events wake processor
// - Reset disables unit, aborts any transfer
// - Start/stop seen cleared by reset, disable
// - Busy bus: detected stop sets event
// - Released one read as zero: collision
// - Arbitration checked in six of the sixteen states
// - Byte collision: halt, clear full, release
// - Sequence collision: abort, release, clear enable
// - Next buffer write restarts at bit one
// - Line low at start: collision, idle
// - Start: SCL low with SDA high collides
// - Early SDA low restarts count; start timing
// - Restart: count, release SCL, check SDA
// - Restart: early SCL fall collides; timing
`include "imsa_defines.vh"

module imsa_master #(
  parameter RATE_WIDTH = 8
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Register port
  input wire [1:0] reg_addr,
  input wire [7:0] reg_wr_data,
  input wire reg_wr_en,
  input wire reg_rd_en,
  output reg [7:0] reg_rd_data,
  // I2C data line, open drain
  input wire sda_in,
  output wire sda_out,
  output reg sda_oe_n,
  // I2C clock line, open drain
  input wire scl_in,
  output wire scl_out,
  output reg scl_oe_n,
  // System
  input wire sleep_mode,
  output reg wake_request,
  output reg collision_irq
);

  // One-hot sequencer states
  localparam [15:0] S_IDLE = 16'h0001;
  localparam [15:0] S_ST_A = 16'h0002;
  localparam [15:0] S_ST_B = 16'h0004;
  localparam [15:0] S_RS_A = 16'h0008;
  localparam [15:0] S_RS_B = 16'h0010;
  localparam [15:0] S_RS_C = 16'h0020;
  localparam [15:0] S_RS_D = 16'h0040;
  localparam [15:0] S_TX_L = 16'h0080;
  localparam [15:0] S_TX_H = 16'h0100;
  localparam [15:0] S_AK_L = 16'h0200;
  localparam [15:0] S_AK_H = 16'h0400;
  localparam [15:0] S_SP_A = 16'h0800;
  localparam [15:0] S_SP_B = 16'h1000;
  localparam [15:0] S_SP_C = 16'h2000;
  localparam [15:0] S_SP_D = 16'h4000;
  localparam [15:0] S_SP_E = 16'h8000;

  reg [15:0] state_reg;
  reg unit_enable_reg;
  reg start_enable_reg;
  reg rstart_enable_reg;
  reg stop_sequence_enable_reg;
  reg ack_sequence_enable_reg;
  reg ack_data_value_reg;
  reg event_ie_reg;
  reg coll_ie_reg;
  reg [RATE_WIDTH-1:0] rate_reload_value_reg;
  reg [7:0] serial_buffer_reg;
  reg [7:0] serial_shift_reg;
  reg [3:0] bit_count_reg;
  reg buffer_full_flag_reg;
  reg write_collision_flag_reg;
  reg bus_collision_flag_reg;
  reg serial_event_flag_reg;
  reg start_seen_reg;
  reg stop_seen_reg;
  reg ack_status_reg;
  reg sda_drive_reg;
  reg scl_drive_reg;
  reg rate_load_reg;
  reg sda_meta_reg;
  reg sda_sync_reg;
  reg scl_meta_reg;
  reg scl_sync_reg;
  reg sda_prev_reg;
  reg scl_prev_reg;

  wire tick;
  wire stretch;
  wire rate_load;
  wire rate_run;
  wire start_det;
  wire stop_det;
  wire coll_now;
  wire busy;
  wire idle;
  wire wr_ctrl;
  wire wr_stat;
  wire wr_buf;

  // Open-drain pins only ever pull low
  assign sda_out = 1'b0;
  assign scl_out = 1'b0;

  // Two-stage synchronisers, then a delayed copy for edge detection
  always @(posedge clk_sys) begin
    if (rst) begin
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
    end else begin
      sda_meta_reg <= sda_in;
      sda_sync_reg <= sda_meta_reg;
      scl_meta_reg <= scl_in;
      scl_sync_reg <= scl_meta_reg;
      sda_prev_reg <= sda_sync_reg;
      scl_prev_reg <= scl_sync_reg;
    end
  end

  // Bus conditions seen on the synchronised lines
  assign start_det = scl_sync_reg && scl_prev_reg &&
                     sda_prev_reg && !sda_sync_reg;
  assign stop_det = scl_sync_reg && scl_prev_reg &&
                    !sda_prev_reg && sda_sync_reg;

  // Another device stretching SCL holds the high-phase count at reload
  assign stretch = ((state_reg == S_TX_H) || (state_reg == S_AK_H) ||
                    (state_reg == S_SP_C)) && !scl_sync_reg;
  assign rate_load = rate_load_reg || stretch;
  assign rate_run = (state_reg != S_IDLE);

  // Arbitration checks in S_ST_A, S_RS_B, S_RS_C, S_TX_H, S_AK_H and S_SP_D only
  assign coll_now =
    ((state_reg == S_ST_A) && sda_sync_reg && !scl_sync_reg) ||
    ((state_reg == S_RS_B) && scl_sync_reg && !sda_sync_reg) ||
    ((state_reg == S_RS_C) && !scl_sync_reg && sda_sync_reg) ||
    ((state_reg == S_TX_H) && scl_sync_reg && !sda_sync_reg &&
     serial_shift_reg[7] && (bit_count_reg != `IMSA_ACK_BIT)) ||
    ((state_reg == S_AK_H) && scl_sync_reg && !sda_sync_reg &&
     ack_data_value_reg) ||
    ((state_reg == S_SP_D) && (!scl_sync_reg ||
     (tick && !sda_sync_reg)));

  assign idle = (state_reg == S_IDLE);
  assign busy = !idle || start_enable_reg || rstart_enable_reg ||
                stop_sequence_enable_reg || ack_sequence_enable_reg;
  assign wr_ctrl = reg_wr_en && (reg_addr == `IMSA_ADDR_CTRL);
  assign wr_stat = reg_wr_en && (reg_addr == `IMSA_ADDR_STAT);
  assign wr_buf = reg_wr_en && (reg_addr == `IMSA_ADDR_BUF);

  imsa_rate_gen #(
    .WIDTH(RATE_WIDTH)
  ) u_rate_gen (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(rate_load),
    .run(rate_run),
    .reload_value(rate_reload_value_reg),
    .tick(tick)
  );

  // Sequencer, register writes and flags; later lines win, so sets win
  always @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= S_IDLE;
      unit_enable_reg <= 1'b0;
      start_enable_reg <= 1'b0;
      rstart_enable_reg <= 1'b0;
      stop_sequence_enable_reg <= 1'b0;
      ack_sequence_enable_reg <= 1'b0;
      ack_data_value_reg <= 1'b0;
      event_ie_reg <= 1'b0;
      coll_ie_reg <= 1'b0;
      rate_reload_value_reg <= `IMSA_RATE_RST;
      serial_buffer_reg <= `IMSA_BUF_RST;
      serial_shift_reg <= 8'h00;
      bit_count_reg <= 4'h0;
      buffer_full_flag_reg <= 1'b0;
      write_collision_flag_reg <= 1'b0;
      bus_collision_flag_reg <= 1'b0;
      serial_event_flag_reg <= 1'b0;
      start_seen_reg <= 1'b0;
      stop_seen_reg <= 1'b0;
      ack_status_reg <= 1'b0;
      sda_drive_reg <= 1'b0;
      scl_drive_reg <= 1'b0;
      rate_load_reg <= 1'b0;
    end else begin
      rate_load_reg <= 1'b0;
      // Software writes; a request bit is only taken while fully idle
      if (wr_ctrl) begin
        unit_enable_reg <= reg_wr_data[`IMSA_CTRL_UNIT_EN];
        ack_data_value_reg <= reg_wr_data[`IMSA_CTRL_ACK_DATA];
        event_ie_reg <= reg_wr_data[`IMSA_CTRL_EVENT_IE];
        coll_ie_reg <= reg_wr_data[`IMSA_CTRL_COLL_IE];
        if (unit_enable_reg && !busy) begin
          start_enable_reg <= reg_wr_data[`IMSA_CTRL_START];
          rstart_enable_reg <= reg_wr_data[`IMSA_CTRL_RSTART];
          stop_sequence_enable_reg <= reg_wr_data[`IMSA_CTRL_STOP];
          ack_sequence_enable_reg <= reg_wr_data[`IMSA_CTRL_ACK];
        end
      end
      if (wr_stat) begin
        if (reg_wr_data[`IMSA_STAT_WRITE_COLLISION_FLAG]) begin
          write_collision_flag_reg <= 1'b0;
        end
        if (reg_wr_data[`IMSA_STAT_BCOL]) begin
          bus_collision_flag_reg <= 1'b0;
        end
        if (reg_wr_data[`IMSA_STAT_EVENT]) begin
          serial_event_flag_reg <= 1'b0;
        end
      end
      if (reg_wr_en && (reg_addr == `IMSA_ADDR_RATE)) begin
        rate_reload_value_reg <= reg_wr_data[RATE_WIDTH-1:0];
      end
      // A buffer write while any sequence runs is refused
      if (wr_buf && busy) begin
        write_collision_flag_reg <= 1'b1;
      end
      // Bus monitor keeps running whatever the sequencer does
      if (start_det) begin
        start_seen_reg <= 1'b1;
        stop_seen_reg <= 1'b0;
      end
      if (stop_det) begin
        stop_seen_reg <= 1'b1;
        start_seen_reg <= 1'b0;
        if (idle && start_seen_reg) begin
          serial_event_flag_reg <= 1'b1;
        end
      end
      case (state_reg)
        S_IDLE: begin
          if (wr_buf && !busy && unit_enable_reg) begin
            serial_buffer_reg <= reg_wr_data;
            serial_shift_reg <= reg_wr_data;
            bit_count_reg <= 4'h0;
            buffer_full_flag_reg <= 1'b1;
            sda_drive_reg <= !reg_wr_data[7];
            scl_drive_reg <= 1'b1;
            rate_load_reg <= 1'b1;
            state_reg <= S_TX_L;
          end else if (start_enable_reg) begin
            if (!sda_sync_reg || !scl_sync_reg) begin
              start_enable_reg <= 1'b0;
              bus_collision_flag_reg <= 1'b1;
              sda_drive_reg <= 1'b0;
              scl_drive_reg <= 1'b0;
            end else begin
              rate_load_reg <= 1'b1;
              state_reg <= S_ST_A;
            end
          end else if (rstart_enable_reg) begin
            sda_drive_reg <= 1'b0;
            rate_load_reg <= 1'b1;
            state_reg <= S_RS_A;
          end else if (stop_sequence_enable_reg) begin
            sda_drive_reg <= 1'b1;
            state_reg <= S_SP_A;
          end else if (ack_sequence_enable_reg) begin
            scl_drive_reg <= 1'b1;
            sda_drive_reg <= !ack_data_value_reg;
            rate_load_reg <= 1'b1;
            state_reg <= S_AK_L;
          end
        end
        S_ST_A: begin
          // Another master pulling SDA first: restart the count now
          if (!sda_sync_reg || tick) begin
            sda_drive_reg <= 1'b1;
            rate_load_reg <= 1'b1;
            state_reg <= S_ST_B;
          end
        end
        S_ST_B: begin
          // SCL low samples are ignored here
          if (tick) begin
            scl_drive_reg <= 1'b1;
            start_enable_reg <= 1'b0;
            serial_event_flag_reg <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        S_RS_A: begin
          if (tick) begin
            scl_drive_reg <= 1'b0;
            state_reg <= S_RS_B;
          end
        end
        S_RS_B: begin
          if (scl_sync_reg && sda_sync_reg) begin
            rate_load_reg <= 1'b1;
            state_reg <= S_RS_C;
          end
        end
        S_RS_C: begin
          // An early SDA fall from another master is not a collision
          if (tick) begin
            sda_drive_reg <= 1'b1;
            rate_load_reg <= 1'b1;
            state_reg <= S_RS_D;
          end
        end
        S_RS_D: begin
          if (tick) begin
            scl_drive_reg <= 1'b1;
            rstart_enable_reg <= 1'b0;
            serial_event_flag_reg <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        S_TX_L: begin
          if (tick) begin
            scl_drive_reg <= 1'b0;
            state_reg <= S_TX_H;
          end
        end
        S_TX_H: begin
          if (tick) begin
            scl_drive_reg <= 1'b1;
            rate_load_reg <= 1'b1;
            if (bit_count_reg == `IMSA_ACK_BIT) begin
              ack_status_reg <= sda_sync_reg;
              serial_event_flag_reg <= 1'b1;
              state_reg <= S_IDLE;
            end else begin
              bit_count_reg <= bit_count_reg + 4'h1;
              serial_shift_reg <= {serial_shift_reg[6:0], 1'b0};
              if (bit_count_reg == `IMSA_LAST_DATA_BIT) begin
                buffer_full_flag_reg <= 1'b0;
                sda_drive_reg <= 1'b0;
              end else begin
                sda_drive_reg <= !serial_shift_reg[6];
              end
              state_reg <= S_TX_L;
            end
          end
        end
        S_AK_L: begin
          if (tick) begin
            scl_drive_reg <= 1'b0;
            state_reg <= S_AK_H;
          end
        end
        S_AK_H: begin
          if (tick) begin
            scl_drive_reg <= 1'b1;
            ack_sequence_enable_reg <= 1'b0;
            serial_event_flag_reg <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        S_SP_A: begin
          if (!sda_sync_reg) begin
            rate_load_reg <= 1'b1;
            state_reg <= S_SP_B;
          end
        end
        S_SP_B: begin
          if (tick) begin
            scl_drive_reg <= 1'b0;
            state_reg <= S_SP_C;
          end
        end
        S_SP_C: begin
          if (tick) begin
            sda_drive_reg <= 1'b0;
            state_reg <= S_SP_D;
          end
        end
        S_SP_D: begin
          if (sda_sync_reg && scl_sync_reg) begin
            stop_seen_reg <= 1'b1;
            start_seen_reg <= 1'b0;
            rate_load_reg <= 1'b1;
            state_reg <= S_SP_E;
          end
        end
        S_SP_E: begin
          if (tick) begin
            stop_sequence_enable_reg <= 1'b0;
            serial_event_flag_reg <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
      // Lost arbitration: drop everything, both lines float
      if (coll_now) begin
        bus_collision_flag_reg <= 1'b1;
        buffer_full_flag_reg <= 1'b0;
        sda_drive_reg <= 1'b0;
        scl_drive_reg <= 1'b0;
        start_enable_reg <= 1'b0;
        rstart_enable_reg <= 1'b0;
        stop_sequence_enable_reg <= 1'b0;
        ack_sequence_enable_reg <= 1'b0;
        state_reg <= S_IDLE;
      end
      // Disabled unit: abort the transfer and forget bus history
      if (!unit_enable_reg) begin
        state_reg <= S_IDLE;
        sda_drive_reg <= 1'b0;
        scl_drive_reg <= 1'b0;
        start_enable_reg <= 1'b0;
        rstart_enable_reg <= 1'b0;
        stop_sequence_enable_reg <= 1'b0;
        ack_sequence_enable_reg <= 1'b0;
        buffer_full_flag_reg <= 1'b0;
        start_seen_reg <= 1'b0;
        stop_seen_reg <= 1'b0;
      end
    end
  end

  // Pin enables and requests are registered to keep them glitch free
  always @(posedge clk_sys) begin
    if (rst) begin
      sda_oe_n <= 1'b1;
      scl_oe_n <= 1'b1;
      wake_request <= 1'b0;
      collision_irq <= 1'b0;
    end else begin
      sda_oe_n <= !sda_drive_reg;
      scl_oe_n <= !scl_drive_reg;
      wake_request <= sleep_mode && event_ie_reg &&
                      serial_event_flag_reg;
      collision_irq <= coll_ie_reg && bus_collision_flag_reg;
    end
  end

  // Read data stand in the cycle after the strobe only
  always @(posedge clk_sys) begin
    if (rst) begin
      reg_rd_data <= 8'h00;
    end else if (reg_rd_en) begin
      case (reg_addr)
        `IMSA_ADDR_CTRL: reg_rd_data <= {coll_ie_reg, event_ie_reg,
          ack_data_value_reg, ack_sequence_enable_reg,
          stop_sequence_enable_reg, rstart_enable_reg,
          start_enable_reg, unit_enable_reg};
        `IMSA_ADDR_STAT: reg_rd_data <= {ack_status_reg, busy,
          serial_event_flag_reg, bus_collision_flag_reg,
          write_collision_flag_reg, buffer_full_flag_reg,
          stop_seen_reg, start_seen_reg};
        `IMSA_ADDR_RATE: reg_rd_data <= rate_reload_value_reg;
        `IMSA_ADDR_BUF: reg_rd_data <= serial_buffer_reg;
        default: reg_rd_data <= 8'h00;
      endcase
    end else begin
      reg_rd_data <= 8'h00;
    end
  end

endmodule

// ===== rtl/imsa_rate_gen.v
// Reloadable down-counter that marks the end of each rate period
module imsa_rate_gen #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Control
  input wire load,
  input wire run,
  input wire [WIDTH-1:0] reload_value,
  // Result
  output wire tick
);

  reg [WIDTH-1:0] count_reg;

  // A period lasts reload_value + 1 clocks; load restarts it at once
  always @(posedge clk_sys) begin
    if (rst) begin
      count_reg <= {WIDTH{1'b0}};
    end else if (load || !run) begin
      count_reg <= reload_value;
    end else if (count_reg == {WIDTH{1'b0}}) begin
      count_reg <= reload_value;
    end else begin
      count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // Timeout pulse, one clock wide
  assign tick = run && !load && (count_reg == {WIDTH{1'b0}});

endmodule

// ===== tb/imsa_bus_partner.sv
// Far side of the bus: open-drain wires with pull-ups, other masters
module imsa_bus_partner (
  // Link clock of the far side
  input wire logic clk_link,
  // Pulls of the device
  input wire logic sda_oe_n,
  input wire logic scl_oe_n,
  // Requests from the bench
  input wire logic hold_sda_low,
  input wire logic stretch_scl,
  // Wire levels seen by the device
  output wire logic sda_in,
  output wire logic scl_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sda_low_q = 1'b0;
  logic scl_low_q = 1'b0;
  // Far side only changes its pulls on its own clock, never in step
  always @(posedge clk_link) begin
    sda_low_q <= hold_sda_low;
    scl_low_q <= stretch_scl;
  end
  // Pull-ups: any party pulling low wins
  assign sda_in = sda_oe_n & ~sda_low_q;
  assign scl_in = scl_oe_n & ~scl_low_q;
endmodule

// ===== tb/imsa_master_sva.sv
// Port-level timing checks of the I2C master sequencer
module imsa_master_sva #(
  parameter RATE_WIDTH = 8
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Register port
  input wire [1:0] reg_addr,
  input wire [7:0] reg_wr_data,
  input wire reg_wr_en,
  input wire reg_rd_en,
  input wire [7:0] reg_rd_data,
  // Bus lines
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe_n,
  input wire scl_in,
  input wire scl_out,
  input wire scl_oe_n,
  // System
  input wire sleep_mode,
  input wire wake_request,
  input wire collision_irq
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // Reset leaves the lines free and outputs quiet
  reset_state_a: assert property (disable iff (1'b0) rst |=>
    sda_oe_n && scl_oe_n && reg_rd_data == 8'h00 && !collision_irq)
    else $error("outputs not at rest after reset");
  // Read data only in the cycle after a read
  rd_idle_a: assert property (!reg_rd_en |=> reg_rd_data == 8'h00)
    else $error("read data outside its cycle");
  wake_sleep_a: assert property (!sleep_mode |=> !wake_request)
    else $error("wake request while awake");
  // Flag write has one cycle of lag before the request drops
  coll_sticky_a: assert property (collision_irq && !reg_wr_en &&
    !$past(reg_wr_en) |=> collision_irq)
    else $error("collision request dropped by itself");
  coll_release_a: assert property ($rose(collision_irq) |->
    (sda_oe_n && scl_oe_n) [*3])
    else $error("lines held after collision");
  // Rate reload of at least 3 gives periods of 4 cycles or more
  scl_high_min_a: assert property ($rose(scl_oe_n) |-> scl_oe_n [*4])
    else $error("clock released too briefly");
  scl_low_min_a: assert property ($fell(scl_oe_n) |-> !scl_oe_n [*4])
    else $error("clock pulled low too briefly");
  stop_order_a: assert property ($rose(sda_oe_n) && scl_oe_n |->
    $past(scl_oe_n, 4))
    else $error("data released too soon after clock");
  // Open-drain outputs never drive a high level
  pins_low_a: assert property (!sda_out && !scl_out)
    else $error("open-drain output driven high");
endmodule

// ===== tb/test_imsa_master.sv
// Self-checking bench of the I2C master sequencer
`include "imsa_defines.vh"
module test_imsa_master;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic rst = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wr_data = 8'h00;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic sleep_mode = 1'b0;
  logic hold_sda_low = 1'b0;
  logic stretch_scl = 1'b0;
  wire [7:0] reg_rd_data;
  wire sda_in, sda_out, sda_oe_n, scl_in, scl_out, scl_oe_n;
  wire wake_request, collision_irq;
  int fails = 0;
  int checks = 0;
  logic [7:0] v;
  // System clock and a link clock of unrelated phase
  always #10 clk_sys = ~clk_sys;
  initial #3 forever #80 clk_link = ~clk_link;
  imsa_master #(.RATE_WIDTH(8)) DUT (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sleep_mode(sleep_mode), .wake_request(wake_request),
    .collision_irq(collision_irq));
  imsa_bus_partner u_bus (.clk_link(clk_link), .sda_oe_n(sda_oe_n),
    .scl_oe_n(scl_oe_n), .hold_sda_low(hold_sda_low),
    .stretch_scl(stretch_scl), .sda_in(sda_in), .scl_in(scl_in));
  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Register port cycles, launched right after a rising edge
  task automatic wr(logic [1:0] a, logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_en <= 1'b1;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
  endtask
  task automatic rd(logic [1:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    #1 d = reg_rd_data;
  endtask
  // Poll a register until the masked bits clear, bounded
  task automatic wait_clear(logic [1:0] a, logic [7:0] m);
    int n;
    n = 0;
    v = m;
    while ((v & m) != 8'h00 && n < 300) begin
      rd(a, v);
      n++;
    end
    chk("idle wait", 8'h00, v & m);
  endtask
  task automatic wait_scl_free();
    int n;
    n = 0;
    while (scl_oe_n !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk("scl free", 8'h01, {7'h0, scl_oe_n});
  endtask
  task automatic t_reset();
    rd(`IMSA_ADDR_CTRL, v);
    chk("ctrl", 8'h00, v);
    rd(`IMSA_ADDR_STAT, v);
    chk("status", 8'h00, v);
    rd(`IMSA_ADDR_RATE, v);
    chk("rate", `IMSA_RATE_RST, v);
    rd(`IMSA_ADDR_BUF, v);
    chk("buffer", `IMSA_BUF_RST, v);
    chk("lines", 8'h03, {6'h0, sda_oe_n, scl_oe_n});
  endtask
  // Ack with both data values; far side stretches the clock
  task automatic t_ack();
    // Request bits are only taken once the unit is already enabled
    wr(`IMSA_ADDR_CTRL, 8'h01);
    for (int i = 0; i < 2; i++) begin
      stretch_scl <= 1'b1;
      repeat (10) @(posedge clk_sys);
      wr(`IMSA_ADDR_CTRL, {2'b00, i[0], 5'h11});
      repeat (3) @(posedge clk_sys);
      #1 chk("ack pins", {6'h0, i[0], 1'b0}, {6'h0, sda_oe_n, scl_oe_n});
      wr(`IMSA_ADDR_BUF, 8'h5a);
      wait_scl_free();
      repeat (20) @(posedge clk_sys);
      rd(`IMSA_ADDR_CTRL, v);
      chk("ack waits", {2'b00, i[0], 5'h11}, v);
      stretch_scl <= 1'b0;
      wait_clear(`IMSA_ADDR_CTRL, 8'h1e);
      rd(`IMSA_ADDR_STAT, v);
      chk("ack flags", 8'h28, v & 8'h28);
      rd(`IMSA_ADDR_BUF, v);
      chk("buffer kept", 8'h00, v);
      wr(`IMSA_ADDR_STAT, 8'h38);
    end
  endtask
  task automatic t_stop();
    wr(`IMSA_ADDR_CTRL, 8'h09);
    repeat (3) @(posedge clk_sys);
    #1 chk("stop sda", 8'h00, {7'h0, sda_oe_n});
    wr(`IMSA_ADDR_BUF, 8'h77);
    wait_clear(`IMSA_ADDR_CTRL, 8'h1e);
    rd(`IMSA_ADDR_STAT, v);
    chk("stop flags", 8'h2a, v & 8'h2a);
    rd(`IMSA_ADDR_BUF, v);
    chk("buffer kept", 8'h00, v);
    wr(`IMSA_ADDR_CTRL, 8'h00);
    rd(`IMSA_ADDR_STAT, v);
    chk("seen cleared", 8'h00, v & 8'h03);
    wr(`IMSA_ADDR_STAT, 8'h38);
  endtask
  // Start while another party holds SDA low
  task automatic t_start_coll();
    hold_sda_low <= 1'b1;
    repeat (10) @(posedge clk_sys);
    wr(`IMSA_ADDR_CTRL, 8'h81);
    wr(`IMSA_ADDR_CTRL, 8'h83);
    wait_clear(`IMSA_ADDR_CTRL, 8'h1e);
    rd(`IMSA_ADDR_STAT, v);
    chk("start coll", 8'h10, v & 8'h10);
    chk("lines", 8'h03, {6'h0, sda_oe_n, scl_oe_n});
    chk("coll irq", 8'h01, {7'h0, collision_irq});
    wr(`IMSA_ADDR_STAT, 8'h10);
    repeat (2) @(posedge clk_sys);
    #1 chk("irq cleared", 8'h00, {7'h0, collision_irq});
    hold_sda_low <= 1'b0;
  endtask
  // Byte loses arbitration on its third bit, then is resent
  task automatic t_byte_coll();
    int n;
    repeat (20) @(posedge clk_sys);
    wr(`IMSA_ADDR_CTRL, 8'h83);
    wait_clear(`IMSA_ADDR_CTRL, 8'h1e);
    chk("start scl", 8'h00, {7'h0, scl_oe_n});
    hold_sda_low <= 1'b1;
    repeat (10) @(posedge clk_sys);
    wr(`IMSA_ADDR_BUF, 8'h3f);
    rd(`IMSA_ADDR_STAT, v);
    chk("buf full", 8'h04, v & 8'h04);
    wait_clear(`IMSA_ADDR_STAT, 8'h40);
    chk("byte coll", 8'h10, v & 8'h14);
    chk("lines", 8'h03, {6'h0, sda_oe_n, scl_oe_n});
    // Clear first, so the event set by the stop on release is not wiped out
    wr(`IMSA_ADDR_STAT, 8'h38);
    hold_sda_low <= 1'b0;
    repeat (14) @(posedge clk_sys);
    rd(`IMSA_ADDR_STAT, v);
    chk("bus stop", 8'h22, v & 8'h22);
    wr(`IMSA_ADDR_BUF, 8'h3f);
    n = 0;
    while (sda_oe_n !== 1'b0 && n < 60) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk("first bit", 8'h00, {7'h0, sda_oe_n});
    wait_clear(`IMSA_ADDR_STAT, 8'h40);
    chk("nack kept", 8'h80, v & 8'h84);
    rd(`IMSA_ADDR_BUF, v);
    chk("buffer", 8'h3f, v);
  endtask
  // Repeated start, clean and then against SDA held low
  task automatic t_restart();
    wr(`IMSA_ADDR_CTRL, 8'h85);
    wait_clear(`IMSA_ADDR_CTRL, 8'h1e);
    rd(`IMSA_ADDR_STAT, v);
    chk("restart", 8'h01, v & 8'h11);
    chk("restart pins", 8'h00, {6'h0, sda_oe_n, scl_oe_n});
    hold_sda_low <= 1'b1;
    repeat (10) @(posedge clk_sys);
    wr(`IMSA_ADDR_CTRL, 8'h85);
    wait_clear(`IMSA_ADDR_CTRL, 8'h1e);
    rd(`IMSA_ADDR_STAT, v);
    chk("restart coll", 8'h10, v & 8'h10);
    chk("lines", 8'h03, {6'h0, sda_oe_n, scl_oe_n});
    hold_sda_low <= 1'b0;
    wr(`IMSA_ADDR_STAT, 8'h10);
  endtask
  task automatic t_wake();
    wr(`IMSA_ADDR_CTRL, 8'hc1);
    sleep_mode <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 chk("wake", 8'h01, {7'h0, wake_request});
    @(posedge clk_sys);
    sleep_mode <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 chk("awake", 8'h00, {7'h0, wake_request});
  endtask
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    wr(`IMSA_ADDR_RATE, 8'h03);
    t_ack();
    t_stop();
    t_start_coll();
    t_byte_coll();
    t_restart();
    t_wake();
    complete_run();
  end
  // Watchdog: the whole sequence needs well under this span
  initial begin
    #400000;
    fails++;
    complete_run();
  end
endmodule
bind imsa_master imsa_master_sva #(.RATE_WIDTH(RATE_WIDTH)) u_sva (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
  .reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en),
  .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
  .sleep_mode(sleep_mode), .wake_request(wake_request),
  .collision_irq(collision_irq));
